// File: core/cwd_pkg.sv
package cwd_pkg;

  // ==========================================================================
  // widths and word map
  // ==========================================================================
  localparam int unsigned CWD_WORD_W = 24;
  localparam int unsigned CWD_ADDR_W = 3;
  localparam int unsigned CWD_THR_W  = 32;

  localparam logic [CWD_ADDR_W-1:0] CWD_ADDR_CNT_LO = 3'h0;
  localparam logic [CWD_ADDR_W-1:0] CWD_ADDR_CNT_HI = 3'h1;
  localparam logic [CWD_ADDR_W-1:0] CWD_ADDR_DIS    = 3'h2;
  localparam logic [CWD_ADDR_W-1:0] CWD_ADDR_OPT    = 3'h3;
  localparam logic [CWD_ADDR_W-1:0] CWD_ADDR_IDENT  = 3'h4;
  localparam logic [CWD_ADDR_W-1:0] CWD_ADDR_REV    = 3'h5;

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int unsigned CWD_CNT_MSB     = 15;
  localparam int unsigned CWD_DIS_BIT     = 0;
  localparam int unsigned CWD_OPT_SMB3    = 10;
  localparam int unsigned CWD_OPT_CMP2    = 5;
  localparam int unsigned CWD_OPT_I2C1    = 4;
  localparam int unsigned CWD_OPT_OSC_HP  = 3;
  localparam int unsigned CWD_OPT_TAMPER  = 2;
  localparam int unsigned CWD_OPT_CMP1    = 1;

  // ==========================================================================
  // unprogrammed values and implemented-bit masks
  // ==========================================================================
  localparam logic [CWD_WORD_W-1:0] CWD_RST_CNT_LO = 24'h00ffff;
  localparam logic [CWD_WORD_W-1:0] CWD_RST_CNT_HI = 24'h000001;
  localparam logic [CWD_WORD_W-1:0] CWD_RST_DIS    = 24'h000001;
  localparam logic [CWD_WORD_W-1:0] CWD_RST_OPT    = 24'h00043e;
  localparam logic [CWD_WORD_W-1:0] CWD_MASK_CNT   = 24'h00ffff;
  localparam logic [CWD_WORD_W-1:0] CWD_MASK_DIS   = 24'h000001;
  localparam logic [CWD_WORD_W-1:0] CWD_MASK_OPT   = 24'h00043e;

  // arbitrary identification values
  localparam logic [CWD_WORD_W-1:0] CWD_DEF_IDENT  = 24'h005a5a;
  localparam logic [CWD_WORD_W-1:0] CWD_DEF_REV    = 24'h000001;

  // load sequence after reset, gray along the path
  typedef enum logic [1:0] {
    CWD_ST_LOAD  = 2'b00,
    CWD_ST_APPLY = 2'b01,
    CWD_ST_RUN   = 2'b11
  } cwd_state_t;

  // blank array reads as the unprogrammed value; bits outside the mask read zero
  function automatic logic [CWD_WORD_W-1:0] cwd_pick(input logic [CWD_WORD_W-1:0] img,
                                                     input logic [CWD_WORD_W-1:0] rst,
                                                     input logic [CWD_WORD_W-1:0] mask,
                                                     input logic                  blank);
    cwd_pick = (blank ? rst : img) & mask;
  endfunction

endpackage

// File: core/cwd_word_latch.sv
`timescale 1ns/1ps
module cwd_word_latch #(
  parameter logic [23:0] RST_VAL = 24'h000000,
  parameter logic [23:0] MASK    = 24'hffffff
) (
  input  wire logic                           clk_i,
  input  wire logic                           srst_i,
  input  wire logic                           blank_i,
  input  wire logic [cwd_pkg::CWD_WORD_W-1:0] image_i,
  output logic      [cwd_pkg::CWD_WORD_W-1:0] word_o
);
  import cwd_pkg::*;

  logic [CWD_WORD_W-1:0] word_q;

  // ==========================================================================
  // capture
  // ==========================================================================
  // sampled only while reset is held, so nothing at run time can alter it
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      word_q <= cwd_pick(image_i, RST_VAL, MASK, blank_i); // RULE_13
    end
  end

  assign word_o = word_q;

endmodule

// File: core/cwd_option_decode.sv
`timescale 1ns/1ps
module cwd_option_decode (
  input  wire logic [cwd_pkg::CWD_WORD_W-1:0] opt_i,
  input  wire logic                           sec_osc_select_i,
  input  wire logic                           smbus_mode_on_i,
  output logic                                i2c1_alt_pins_o,
  output logic                                comp2_alt_o,
  output logic                                comp13_alt_o,
  output logic                                tamper_enable_o,
  output logic                                sec_osc_high_power_o,
  output logic                                smbus3_levels_o
);
  import cwd_pkg::*;

  // ==========================================================================
  // option decode
  // ==========================================================================
  // a zero bit selects the alternate pins, or for bit 2 enables the tamper input
  assign i2c1_alt_pins_o = ~opt_i[CWD_OPT_I2C1]; // RULE_04
  assign comp2_alt_o     = ~opt_i[CWD_OPT_CMP2]; // RULE_05
  assign comp13_alt_o    = ~opt_i[CWD_OPT_CMP1]; // RULE_06
  assign tamper_enable_o = ~opt_i[CWD_OPT_TAMPER]; // RULE_07

  // high power is meaningless unless the secondary oscillator is selected
  assign sec_osc_high_power_o = sec_osc_select_i & opt_i[CWD_OPT_OSC_HP]; // RULE_08

  // thresholds only matter once the i2c port has smbus mode on
  assign smbus3_levels_o = smbus_mode_on_i & opt_i[CWD_OPT_SMB3]; // RULE_09 RULE_10

endmodule

// File: core/cwd_top.sv
`timescale 1ns/1ps
// Operation
// RULE_01: dead-man threshold bits 15:0 come from the low count word bits 15:0.
// RULE_02: threshold bits 31:16 come from the high count word bits 15:0.
// RULE_03: disable word bit 0 high disables the dead-man timer; blank value is 1.
// RULE_04: option bit 4 high keeps i2c port 1 on primary pins, low moves it.
// RULE_05: option bit 5 high keeps comparator 2 C/D inputs primary, low alternate.
// RULE_06: option bit 1 high keeps comparator 1/3 C inputs primary, low alternate.
// RULE_07: option bit 2 high disables the tamper input, low enables it.
// RULE_08: option bit 3 picks oscillator high power, only when oscillator select is 1.
// RULE_09: option bit 10 high picks smbus 3.0 input levels, low normal levels.
// RULE_10: level choice applies only while the i2c control smbus mode bit is on.
// RULE_11: device identifier and revision registers exist and are read-only.
// RULE_12: every config bit reads back its programmed value; run-time writes change nothing.
// RULE_13: config words latch during reset and stay static until the next reset.
module cwd_top #(
  parameter logic [23:0] DEVICE_ID  = cwd_pkg::CWD_DEF_IDENT,
  parameter logic [23:0] DEVICE_REV = cwd_pkg::CWD_DEF_REV
) (
  input  wire logic                           clk_i,
  input  wire logic                           srst_i,
  // programmed image from the configuration array
  input  wire logic                           nvm_blank_i,
  input  wire logic [cwd_pkg::CWD_WORD_W-1:0] nvm_cnt_lo_i,
  input  wire logic [cwd_pkg::CWD_WORD_W-1:0] nvm_cnt_hi_i,
  input  wire logic [cwd_pkg::CWD_WORD_W-1:0] nvm_dis_i,
  input  wire logic [cwd_pkg::CWD_WORD_W-1:0] nvm_opt_i,
  // live controls from neighbouring blocks
  input  wire logic                           sec_osc_select_i,
  input  wire logic                           smbus_mode_on_i,
  // register port
  input  wire logic [cwd_pkg::CWD_ADDR_W-1:0] addr_i,
  input  wire logic [cwd_pkg::CWD_WORD_W-1:0] wr_data_i,
  input  wire logic                           wr_en_i,
  input  wire logic                           rd_en_i,
  output logic      [cwd_pkg::CWD_WORD_W-1:0] rd_data_o,
  output logic                                wr_refused_o,
  // static controls
  output logic                                cfg_valid_o,
  output logic      [cwd_pkg::CWD_THR_W-1:0]  deadman_threshold_o,
  output logic                                deadman_enable_o,
  output logic                                i2c1_alt_pins_o,
  output logic                                comp2_alt_o,
  output logic                                comp13_alt_o,
  output logic                                tamper_enable_o,
  output logic                                sec_osc_high_power_o,
  output logic                                smbus3_levels_o
);
  import cwd_pkg::*;

  // ==========================================================================
  // declarations
  // ==========================================================================
  // latched words, decoded controls and the load sequence
  cwd_state_t            state_q;
  cwd_state_t            state_d;
  logic [CWD_WORD_W-1:0] cnt_lo_w;
  logic [CWD_WORD_W-1:0] cnt_hi_w;
  logic [CWD_WORD_W-1:0] dis_w;
  logic [CWD_WORD_W-1:0] opt_w;
  logic [CWD_WORD_W-1:0] rd_mux_w;
  logic [CWD_THR_W-1:0]  thr_w;
  logic                  i2c_alt_w;
  logic                  cmp2_alt_w;
  logic                  cmp13_alt_w;
  logic                  tamper_en_w;
  logic                  osc_hp_w;
  logic                  smb3_w;
  logic                  live_w;

  // every top-level output has a flop of its own
  logic [CWD_WORD_W-1:0] rd_data_q;
  logic                  wr_refused_q;
  logic                  cfg_valid_q;
  logic [CWD_THR_W-1:0]  thr_q;
  logic                  dm_en_q;
  logic                  i2c_alt_q;
  logic                  cmp2_alt_q;
  logic                  cmp13_alt_q;
  logic                  tamper_en_q;
  logic                  osc_hp_q;
  logic                  smb3_q;

  // ==========================================================================
  // configuration words
  // ==========================================================================
  // one latch per word; each keeps only its implemented bits
  cwd_word_latch #(
    .RST_VAL (CWD_RST_CNT_LO),
    .MASK    (CWD_MASK_CNT)
  ) u_cnt_lo (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .blank_i (nvm_blank_i),
    .image_i (nvm_cnt_lo_i),
    .word_o  (cnt_lo_w)
  );

  cwd_word_latch #(
    .RST_VAL (CWD_RST_CNT_HI),
    .MASK    (CWD_MASK_CNT)
  ) u_cnt_hi (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .blank_i (nvm_blank_i),
    .image_i (nvm_cnt_hi_i),
    .word_o  (cnt_hi_w)
  );

  cwd_word_latch #(
    .RST_VAL (CWD_RST_DIS),
    .MASK    (CWD_MASK_DIS)
  ) u_dis (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .blank_i (nvm_blank_i),
    .image_i (nvm_dis_i),
    .word_o  (dis_w)
  );

  cwd_word_latch #(
    .RST_VAL (CWD_RST_OPT),
    .MASK    (CWD_MASK_OPT)
  ) u_opt (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .blank_i (nvm_blank_i),
    .image_i (nvm_opt_i),
    .word_o  (opt_w)
  );

  // decode works on the latched option word, never on the raw image
  cwd_option_decode u_dec (
    .opt_i                (opt_w),
    .sec_osc_select_i     (sec_osc_select_i),
    .smbus_mode_on_i      (smbus_mode_on_i),
    .i2c1_alt_pins_o      (i2c_alt_w),
    .comp2_alt_o          (cmp2_alt_w),
    .comp13_alt_o         (cmp13_alt_w),
    .tamper_enable_o      (tamper_en_w),
    .sec_osc_high_power_o (osc_hp_w),
    .smbus3_levels_o      (smb3_w)
  );

  // ==========================================================================
  // decode
  // ==========================================================================
  // threshold is the two 16-bit halves side by side
  assign thr_w = {cnt_hi_w[CWD_CNT_MSB:0], cnt_lo_w[CWD_CNT_MSB:0]}; // RULE_01 RULE_02

  // identity words are constants, never stored, so no write path exists
  assign rd_mux_w = (addr_i == CWD_ADDR_CNT_LO) ? cnt_lo_w :
                    (addr_i == CWD_ADDR_CNT_HI) ? cnt_hi_w :
                    (addr_i == CWD_ADDR_DIS)    ? dis_w    :
                    (addr_i == CWD_ADDR_OPT)    ? opt_w    :
                    (addr_i == CWD_ADDR_IDENT)  ? DEVICE_ID  : // RULE_11
                    (addr_i == CWD_ADDR_REV)    ? DEVICE_REV :
                    '0;

  // outputs are refreshed once the words have settled out of reset
  assign live_w = (state_q != CWD_ST_LOAD);

  // ==========================================================================
  // load sequence
  // ==========================================================================
  // two settle cycles let the latched words meet the live inputs before the pins see them
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      CWD_ST_LOAD:  state_d = CWD_ST_APPLY;
      CWD_ST_APPLY: state_d = CWD_ST_RUN;
      CWD_ST_RUN:   state_d = CWD_ST_RUN;
      default:      state_d = CWD_ST_LOAD;
    endcase
  end

  // any reset restarts the load, so a mid-run reset applies fresh words
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= CWD_ST_LOAD;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // register port
  // ==========================================================================
  // read data stand one cycle only; writes are flagged and dropped
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rd_data_q    <= '0;
      wr_refused_q <= 1'b0;
    end else begin
      rd_data_q    <= rd_en_i ? rd_mux_w : '0; // RULE_12
      wr_refused_q <= wr_en_i; // RULE_12
    end
  end

  // ==========================================================================
  // static control outputs
  // ==========================================================================
  // during reset everything sits in its safe state: timer off, primary pins
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cfg_valid_q <= 1'b0;
      thr_q       <= '0;
      dm_en_q     <= 1'b0;
      i2c_alt_q   <= 1'b0;
      cmp2_alt_q  <= 1'b0;
      cmp13_alt_q <= 1'b0;
      tamper_en_q <= 1'b0;
      osc_hp_q    <= 1'b0;
      smb3_q      <= 1'b0;
    end else if (live_w) begin
      cfg_valid_q <= 1'b1; // RULE_13
      thr_q       <= thr_w;
      dm_en_q     <= ~dis_w[CWD_DIS_BIT]; // RULE_03
      i2c_alt_q   <= i2c_alt_w;
      cmp2_alt_q  <= cmp2_alt_w;
      cmp13_alt_q <= cmp13_alt_w;
      tamper_en_q <= tamper_en_w;
      osc_hp_q    <= osc_hp_w;
      smb3_q      <= smb3_w;
    end
  end

  assign rd_data_o            = rd_data_q;
  assign wr_refused_o         = wr_refused_q;
  assign cfg_valid_o          = cfg_valid_q;
  assign deadman_threshold_o  = thr_q;
  assign deadman_enable_o     = dm_en_q;
  assign i2c1_alt_pins_o      = i2c_alt_q;
  assign comp2_alt_o          = cmp2_alt_q;
  assign comp13_alt_o         = cmp13_alt_q;
  assign tamper_enable_o      = tamper_en_q;
  assign sec_osc_high_power_o = osc_hp_q;
  assign smbus3_levels_o      = smb3_q;

  // ==========================================================================
  // assertions
  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  thr_low_a: assert property (cfg_valid_o |-> deadman_threshold_o[15:0] == cnt_lo_w[15:0]) // RULE_01
    else $error("threshold low half differs from low count word");
  thr_high_a: assert property (cfg_valid_o |-> deadman_threshold_o[31:16] == cnt_hi_w[15:0]) // RULE_02
    else $error("threshold high half differs from high count word");
  // static controls against the latched words once valid
  dm_disable_a: assert property (cfg_valid_o |-> deadman_enable_o == !dis_w[0]) // RULE_03
    else $error("dead-man enable does not follow disable bit");
  i2c_pins_a: assert property (cfg_valid_o |-> i2c1_alt_pins_o == !opt_w[4]) // RULE_04
    else $error("i2c port 1 pin choice wrong");
  comp2_pins_a: assert property (cfg_valid_o |-> comp2_alt_o == !opt_w[5]) // RULE_05
    else $error("comparator 2 input choice wrong");
  comp13_pins_a: assert property (cfg_valid_o |-> comp13_alt_o == !opt_w[1]) // RULE_06
    else $error("comparator 1/3 input choice wrong");
  tamper_pin_a: assert property (cfg_valid_o |-> tamper_enable_o == !opt_w[2]) // RULE_07
    else $error("tamper enable wrong");
  osc_power_a: assert property (live_w |=> sec_osc_high_power_o == ($past(sec_osc_select_i) && opt_w[3])) // RULE_08
    else $error("oscillator power mode wrong");
  smb3_level_a: assert property (live_w && smbus_mode_on_i |=> smbus3_levels_o == opt_w[10]) // RULE_09
    else $error("smbus level choice wrong");
  smb_gate_a: assert property (live_w && !smbus_mode_on_i |=> !smbus3_levels_o) // RULE_10
    else $error("smbus levels applied without smbus mode");
  id_read_a: assert property (rd_en_i && addr_i == 3'h4 ##1 rd_en_i && addr_i == 3'h5 |->
                              rd_data_o == DEVICE_ID ##1 rd_data_o == DEVICE_REV) // RULE_11
    else $error("identification read wrong");
  write_hold_a: assert property (wr_en_i |=> $stable(opt_w) && $stable(cnt_lo_w) && $stable(cnt_hi_w)
                                 && $stable(dis_w) && wr_refused_o) // RULE_12
    else $error("run-time write altered a config word");
  read_back_a: assert property (rd_en_i && addr_i == 3'h3 |=> rd_data_o == opt_w) // RULE_12
    else $error("option word read-back wrong");
  load_seq_a: assert property ($rose(live_w) |-> !cfg_valid_o ##1 cfg_valid_o[*3]) // RULE_13
    else $error("config outputs not valid two cycles after reset");

  // safe state until the words are applied, then the static controls never move
  reset_safe_a: assert property (!cfg_valid_o |-> deadman_threshold_o == '0 && !deadman_enable_o // RULE_13
                                 && !i2c1_alt_pins_o && !comp2_alt_o && !comp13_alt_o && !tamper_enable_o)
    else $error("control outputs left their safe state before the load");
  cfg_hold_a: assert property (cfg_valid_o |=> cfg_valid_o) // RULE_13
    else $error("config valid dropped without a reset");
  ctl_static_a: assert property (cfg_valid_o |=> $stable(deadman_threshold_o) // RULE_13
                                 && $stable(deadman_enable_o) && $stable(i2c1_alt_pins_o)
                                 && $stable(comp2_alt_o) && $stable(comp13_alt_o) && $stable(tamper_enable_o))
    else $error("static control output moved at run time");

  // without a strobe the read port shows zero and the refusal flag stays low
  rd_idle_a: assert property (!rd_en_i |=> rd_data_o == '0) // RULE_12
    else $error("read data present without a read strobe");
  unmapped_rd_a: assert property (rd_en_i && addr_i > 3'h5 |=> rd_data_o == '0) // RULE_12
    else $error("unmapped word did not read zero");
  refuse_pulse_a: assert property (!wr_en_i |=> !wr_refused_o) // RULE_12
    else $error("write refusal flag without a write");

  // main scenarios: load, refused write, both live-gated options, an identity pair
  run_reached_c: cover property ($rose(cfg_valid_o));
  write_try_c: cover property (wr_en_i ##1 rd_en_i);
  smb3_on_c: cover property (smbus3_levels_o);
  osc_hp_c: cover property (sec_osc_high_power_o);
  id_pair_c: cover property (rd_en_i && addr_i == 3'h4 ##1 rd_en_i && addr_i == 3'h5);

endmodule

// File: tb/config_word_option_decode_bench.sv
`timescale 1ns/1ps
module config_word_option_decode_bench;
  import cwd_pkg::*;

  // ==========================================================================
  // stimulus and observed signals
  // ==========================================================================
  logic                  clk, srst, blank, sel, smb, wr_en, rd_en;
  logic [CWD_WORD_W-1:0] lo_img, hi_img, dis_img, opt_img, wdata, rdata;
  logic [CWD_ADDR_W-1:0] addr;
  logic                  refused, valid, dm_en, i2c_alt, c2_alt, c13_alt, tamp_en, hp, smb3;
  logic [CWD_THR_W-1:0]  thr;
  int                    fail_count, num_checks, cycles;

  // arbitrary identification values, distinct from the package defaults
  localparam logic [23:0] TB_ID  = 24'h00c3c3;
  localparam logic [23:0] TB_REV = 24'h000007;

  // two images that set and clear every implemented bit between them
  logic [23:0] t_lo[2]  = '{24'h5a1234, 24'ha5edcb};
  logic [23:0] t_hi[2]  = '{24'h7f8001, 24'h807ffe};
  logic [23:0] t_dis[2] = '{24'hfffffe, 24'h000001};
  logic [23:0] t_opt[2] = '{24'h000414, 24'hfffbeb};

  cwd_top #(.DEVICE_ID(TB_ID), .DEVICE_REV(TB_REV)) dut (
    .clk_i(clk), .srst_i(srst), .nvm_blank_i(blank),
    .nvm_cnt_lo_i(lo_img), .nvm_cnt_hi_i(hi_img), .nvm_dis_i(dis_img), .nvm_opt_i(opt_img),
    .sec_osc_select_i(sel), .smbus_mode_on_i(smb),
    .addr_i(addr), .wr_data_i(wdata), .wr_en_i(wr_en), .rd_en_i(rd_en),
    .rd_data_o(rdata), .wr_refused_o(refused), .cfg_valid_o(valid),
    .deadman_threshold_o(thr), .deadman_enable_o(dm_en),
    .i2c1_alt_pins_o(i2c_alt), .comp2_alt_o(c2_alt), .comp13_alt_o(c13_alt),
    .tamper_enable_o(tamp_en), .sec_osc_high_power_o(hp), .smbus3_levels_o(smb3)
  );

  // ==========================================================================
  // clock, hang guard and closing report
  // ==========================================================================
  always #4 clk = ~clk;

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      end_of_test();
    end
  end

  // ==========================================================================
  // compare tasks
  // ==========================================================================
  task automatic chk_word(input string what, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_thr(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  // ==========================================================================
  // bus and reset helpers
  // ==========================================================================
  // images must already be steady at the last reset edge, so they go in with srst
  task automatic do_reset(input logic b, input logic [23:0] l, h, d, o);
    @(posedge clk);
    blank <= b; lo_img <= l; hi_img <= h; dis_img <= d; opt_img <= o; srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1 chk_bit("valid in reset", 1'b0, valid);
    repeat (2) @(posedge clk);
    #1 chk_bit("valid after load", 1'b1, valid);
  endtask

  task automatic rd(input logic [2:0] a, input logic [23:0] exp, input string what);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk_word(what, exp, rdata);
  endtask

  task automatic wr(input logic [2:0] a, input logic [23:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    #1 chk_bit("wr_refused", 1'b1, refused);
  endtask

  // static outputs against the image and the live inputs now applied
  task automatic check_ctl(input logic [23:0] l, h, d, o);
    logic [23:0] m;
    m = o & CWD_MASK_OPT;
    chk_thr("threshold", {h[15:0], l[15:0]}, thr);
    chk_bit("dm_enable", ~d[0], dm_en);
    chk_bit("i2c_alt", ~m[CWD_OPT_I2C1], i2c_alt);
    chk_bit("comp2_alt", ~m[CWD_OPT_CMP2], c2_alt);
    chk_bit("comp13_alt", ~m[CWD_OPT_CMP1], c13_alt);
    chk_bit("tamper_en", ~m[CWD_OPT_TAMPER], tamp_en);
    chk_bit("osc_hp", sel & m[CWD_OPT_OSC_HP], hp);
    chk_bit("smb3", smb & m[CWD_OPT_SMB3], smb3);
  endtask

  task automatic check_reads(input logic [23:0] l, h, d, o);
    rd(CWD_ADDR_CNT_LO, l & CWD_MASK_CNT, "rd cnt_lo");
    rd(CWD_ADDR_CNT_HI, h & CWD_MASK_CNT, "rd cnt_hi");
    rd(CWD_ADDR_DIS, d & CWD_MASK_DIS, "rd dis");
    rd(CWD_ADDR_OPT, o & CWD_MASK_OPT, "rd opt");
    rd(CWD_ADDR_IDENT, TB_ID, "rd ident");
    rd(CWD_ADDR_REV, TB_REV, "rd revision");
    rd(3'h6, 24'h000000, "rd unmapped 6");
    rd(3'h7, 24'h000000, "rd unmapped 7");
  endtask

  // ==========================================================================
  // scenarios
  // ==========================================================================
  // blank array: garbage images must be ignored in favour of unprogrammed values
  task automatic test_blank;
    sel <= 1'b1;
    smb <= 1'b1;
    do_reset(1'b1, 24'h000000, 24'hfffffe, 24'h000000, 24'h000000);
    check_ctl(CWD_RST_CNT_LO, CWD_RST_CNT_HI, CWD_RST_DIS, CWD_RST_OPT);
    check_reads(CWD_RST_CNT_LO, CWD_RST_CNT_HI, CWD_RST_DIS, CWD_RST_OPT);
    $display("test blank done");
  endtask

  // programmed images, each under all four live-input combinations; reset again mid-run
  task automatic test_images;
    for (int k = 0; k < 2; k++) begin
      do_reset(1'b0, t_lo[k], t_hi[k], t_dis[k], t_opt[k]);
      for (int i = 0; i < 4; i++) begin
        @(posedge clk);
        {sel, smb} <= i[1:0];
        repeat (2) @(posedge clk);
        #1 check_ctl(t_lo[k], t_hi[k], t_dis[k], t_opt[k]);
      end
      check_reads(t_lo[k], t_hi[k], t_dis[k], t_opt[k]);
    end
    $display("test images done");
  endtask

  // writes at every address are refused and leave words and controls alone
  task automatic test_writes;
    for (int a = 0; a < 8; a++) begin
      wr(a[2:0], 24'h5a5a5a ^ 24'(a));
    end
    check_reads(t_lo[1], t_hi[1], t_dis[1], t_opt[1]);
    check_ctl(t_lo[1], t_hi[1], t_dis[1], t_opt[1]);
    $display("test writes done");
  endtask

  // back-to-back reads with no gap; data stands one cycle, then returns to zero
  task automatic test_b2b;
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= CWD_ADDR_IDENT;
    @(posedge clk);
    addr  <= CWD_ADDR_REV;
    #1 chk_word("b2b ident", TB_ID, rdata);
    @(posedge clk);
    addr  <= CWD_ADDR_CNT_HI;
    #1 chk_word("b2b revision", TB_REV, rdata);
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk_word("b2b cnt_hi", t_hi[1] & CWD_MASK_CNT, rdata);
    @(posedge clk);
    #1 chk_word("rd idle", 24'h000000, rdata);
    $display("test b2b done");
  endtask

  // image inputs moving after reset must not reach the latched words
  task automatic test_static;
    @(posedge clk);
    blank <= 1'b1; lo_img <= t_lo[0]; hi_img <= t_hi[0]; dis_img <= t_dis[0]; opt_img <= t_opt[0];
    repeat (4) @(posedge clk);
    #1 check_ctl(t_lo[1], t_hi[1], t_dis[1], t_opt[1]);
    check_reads(t_lo[1], t_hi[1], t_dis[1], t_opt[1]);
    $display("test static done");
  endtask

  initial begin
    clk = 1'b0; srst = 1'b1; blank = 1'b0; sel = 1'b0; smb = 1'b0;
    wr_en = 1'b0; rd_en = 1'b0; addr = '0; wdata = '0;
    lo_img = '0; hi_img = '0; dis_img = '0; opt_img = '0;
    fail_count = 0; num_checks = 0; cycles = 0;
    test_blank();
    test_images();
    test_writes();
    test_b2b();
    test_static();
    end_of_test();
  end
endmodule
